// File: design/pem_defs.vh
// Register map, field positions and reset values of the pin function mux
`ifndef PEM_DEFS_VH
`define PEM_DEFS_VH

`define PEM_NPINS          6
`define PEM_OFF_PORT       8'h00
`define PEM_OFF_LATCH      8'h04
`define PEM_OFF_DIR        8'h08
`define PEM_OFF_MEMCTL     8'h0C
`define PEM_OFF_SLVCTL     8'h10
`define PEM_OFF_PWMCFG     8'h14
`define PEM_BIT_BUS_DIS    7
`define PEM_BIT_SLV_MODE   4
`define PEM_RST_LATCH      6'h00
`define PEM_RST_DIR        6'h3F
`define PEM_RST_BUS_DIS    1'b1
`define PEM_RST_SLV_MODE   1'b0
`define PEM_RST_PWMCFG     3'h0
`define PEM_RESP_OKAY      2'h0
`define PEM_RESP_SLVERR    2'h2

`endif

// File: design/pem_pin_sync.v
// Three-stage pin synchroniser with agree filter
`timescale 1ns/10ps
module pem_pin_sync
#(
  parameter WIDTH = 6
)
(
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Asynchronous pins in, filtered level out
  input  wire [WIDTH-1:0] pin_async,
  output reg  [WIDTH-1:0] pin_level
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer         i;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1    <= {WIDTH{1'b0}};
      stage2    <= {WIDTH{1'b0}};
      stage3    <= {WIDTH{1'b0}};
      pin_level <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= pin_async;
      stage2 <= stage1;
      stage3 <= stage2;
      // Only a level seen on two stages counts, so one-cycle glitches are dropped
      for (i = 0; i < WIDTH; i = i + 1)
      begin
        if (stage2[i] == stage3[i])
          pin_level[i] <= stage3[i];
      end
    end
  end

endmodule

// File: design/pem_port_mux.v
// Pin function multiplexer for the six low port pins, AXI4-Lite registers
//
// Summary of operation
// - Direction bit one makes a pin input, zero output; 03h gives pins 0-1 inputs.
// - Active memory bus drives bus address/data bits 8-13 onto pins, ignoring direction.
// - During memory read cycles pins are sampled as data bits 8-13.
// - Slave port mode uses pins 0-2 as read, write, chip-select inputs.
// - Module two PWM channels D, C, B drive pins 0-2 when direction zero.
// - Module three PWM channels C, B drive pins 3-4 when direction zero.
// - Module one PWM channel C drives pin 5 when direction zero.
// - PWM pins may optionally float while that module's shutdown is active.
// - Direction zero drives the latch onto the pin; one disables the driver.
// - Memory bus use beats every other function, slave port included.
// - Bus disable bit 7 of memory control releases pins from the memory bus.
// - Slave mode bit 4 makes pins 0-2 inputs whatever their direction bits, unless a PWM claims the pin.
`timescale 1ns/10ps
`include "pem_defs.vh"
module pem_port_mux
(
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // External pins
  input  wire [5:0]  pin_in,
  output reg  [5:0]  pin_out,
  output reg  [5:0]  pin_oe,
  // External memory interface, high address/data bits 8 to 13
  input  wire [5:0]  bus_addr_data_out,
  input  wire        bus_read_cycle,
  output reg  [5:0]  bus_addr_data_in,
  output reg         bus_active,
  // Parallel slave port strobes, active low
  output reg         slave_rd_n,
  output reg         slave_wr_n,
  output reg         slave_cs_n,
  // Enhanced PWM channels
  input  wire        pwm_module_one_enable,
  input  wire        pwm_module_two_enable,
  input  wire        pwm_module_three_enable,
  input  wire        pwm_one_channel_c,
  input  wire        pwm_two_channel_b,
  input  wire        pwm_two_channel_c,
  input  wire        pwm_two_channel_d,
  input  wire        pwm_three_channel_b,
  input  wire        pwm_three_channel_c,
  input  wire        pwm_one_shutdown,
  input  wire        pwm_two_shutdown,
  input  wire        pwm_three_shutdown
);

  reg  [5:0] port_latch;
  reg  [5:0] port_direction_register;
  reg        external_bus_disable;
  reg        slave_port_mode_enable;
  reg  [2:0] pwm_tristate_on_shutdown;
  wire [5:0] pin_level;
  reg  [5:0] next_pin_out;
  reg  [5:0] next_pin_oe;
  reg  [5:0] pwm_claim;
  reg  [5:0] pwm_value;
  reg  [5:0] pwm_float;
  reg  [31:0] rd_word;
  reg        rd_hit;
  integer    i;

  wire bus_on = ~external_bus_disable;
  wire wr_go  = s_axi_awready & s_axi_wready;
  wire [7:0] wbyte = s_axi_wdata[7:0];

  pem_pin_sync #(.WIDTH(6)) u_sync
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_async (pin_in),
    .pin_level (pin_level)
  );

  function addr_known;
    input [7:0] addr;
    begin
      addr_known = (addr == `PEM_OFF_PORT) || (addr == `PEM_OFF_LATCH) ||
                   (addr == `PEM_OFF_DIR) || (addr == `PEM_OFF_MEMCTL) ||
                   (addr == `PEM_OFF_SLVCTL) || (addr == `PEM_OFF_PWMCFG);
    end
  endfunction

  // Write channel: address and data taken together, one write at a time
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready            <= 1'b0;
      s_axi_wready             <= 1'b0;
      s_axi_bvalid             <= 1'b0;
      s_axi_bresp              <= `PEM_RESP_OKAY;
      port_latch               <= `PEM_RST_LATCH;
      port_direction_register  <= `PEM_RST_DIR;
      external_bus_disable     <= `PEM_RST_BUS_DIS;
      slave_port_mode_enable   <= `PEM_RST_SLV_MODE;
      pwm_tristate_on_shutdown <= `PEM_RST_PWMCFG;
    end
    else
    begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= addr_known(s_axi_awaddr) ? `PEM_RESP_OKAY : `PEM_RESP_SLVERR;
        if (s_axi_wstrb[0])
        begin
          if (s_axi_awaddr == `PEM_OFF_PORT)
            port_latch <= wbyte[5:0];
          else if (s_axi_awaddr == `PEM_OFF_LATCH)
            port_latch <= wbyte[5:0];
          else if (s_axi_awaddr == `PEM_OFF_DIR)
            port_direction_register <= wbyte[5:0];
          else if (s_axi_awaddr == `PEM_OFF_MEMCTL)
            external_bus_disable <= wbyte[`PEM_BIT_BUS_DIS];
          else if (s_axi_awaddr == `PEM_OFF_SLVCTL)
            slave_port_mode_enable <= wbyte[`PEM_BIT_SLV_MODE];
          else if (s_axi_awaddr == `PEM_OFF_PWMCFG)
            pwm_tristate_on_shutdown <= wbyte[2:0];
        end
      end
      else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @*
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (s_axi_araddr == `PEM_OFF_PORT)
      rd_word[5:0] = pin_level;
    else if (s_axi_araddr == `PEM_OFF_LATCH)
      rd_word[5:0] = port_latch;
    else if (s_axi_araddr == `PEM_OFF_DIR)
      rd_word[5:0] = port_direction_register;
    else if (s_axi_araddr == `PEM_OFF_MEMCTL)
      rd_word[`PEM_BIT_BUS_DIS] = external_bus_disable;
    else if (s_axi_araddr == `PEM_OFF_SLVCTL)
      rd_word[`PEM_BIT_SLV_MODE] = slave_port_mode_enable;
    else if (s_axi_araddr == `PEM_OFF_PWMCFG)
      rd_word[2:0] = pwm_tristate_on_shutdown;
    else
      rd_hit = 1'b0;
  end

  // Read channel: data captured at the address handshake
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PEM_RESP_OKAY;
    end
    else
    begin
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? `PEM_RESP_OKAY : `PEM_RESP_SLVERR;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

  // PWM claims per pin; only a cleared direction bit lets a PWM drive
  always @*
  begin
    pwm_claim[0] = pwm_module_two_enable & ~port_direction_register[0];
    pwm_claim[1] = pwm_module_two_enable & ~port_direction_register[1];
    pwm_claim[2] = pwm_module_two_enable & ~port_direction_register[2];
    pwm_claim[3] = pwm_module_three_enable & ~port_direction_register[3];
    pwm_claim[4] = pwm_module_three_enable & ~port_direction_register[4];
    pwm_claim[5] = pwm_module_one_enable & ~port_direction_register[5];
    pwm_value    = {pwm_one_channel_c, pwm_three_channel_b, pwm_three_channel_c,
                    pwm_two_channel_b, pwm_two_channel_c, pwm_two_channel_d};
    pwm_float    = {{1{pwm_one_shutdown & pwm_tristate_on_shutdown[0]}},
                    {2{pwm_three_shutdown & pwm_tristate_on_shutdown[2]}},
                    {3{pwm_two_shutdown & pwm_tristate_on_shutdown[1]}}};
  end

  // Priority: memory bus, then PWM, then slave strobes, then plain port
  always @*
  begin
    next_pin_out = 6'h00;
    next_pin_oe  = 6'h00;
    for (i = 0; i < 6; i = i + 1)
    begin
      if (bus_on)
      begin
        next_pin_out[i] = bus_addr_data_out[i];
        next_pin_oe[i]  = ~bus_read_cycle;
      end
      else if (pwm_claim[i])
      begin
        next_pin_out[i] = pwm_value[i];
        next_pin_oe[i]  = ~pwm_float[i];
      end
      else if (slave_port_mode_enable && (i < 3))
      begin
        next_pin_out[i] = port_latch[i];
        next_pin_oe[i]  = 1'b0;
      end
      else
      begin
        next_pin_out[i] = port_latch[i];
        next_pin_oe[i]  = ~port_direction_register[i];
      end
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out          <= 6'h00;
      pin_oe           <= 6'h00;
      bus_addr_data_in <= 6'h00;
      bus_active       <= 1'b0;
      slave_rd_n       <= 1'b1;
      slave_wr_n       <= 1'b1;
      slave_cs_n       <= 1'b1;
    end
    else
    begin
      pin_out    <= next_pin_out;
      pin_oe     <= next_pin_oe;
      bus_active <= bus_on;
      if (bus_on && bus_read_cycle)
        bus_addr_data_in <= pin_level;
      // Strobes are masked while the memory bus owns the pins
      if (slave_port_mode_enable && !bus_on)
      begin
        slave_rd_n <= pin_level[0];
        slave_wr_n <= pin_level[1];
        slave_cs_n <= pin_level[2];
      end
      else
      begin
        slave_rd_n <= 1'b1;
        slave_wr_n <= 1'b1;
        slave_cs_n <= 1'b1;
      end
    end
  end

endmodule

// File: verif/pem_pin_host.sv
// Far-side model: host strobes, memory data and loads on the six pins
`timescale 1ns/10ps
module pem_pin_host
(
  // Device side of the pins
  input  logic [5:0] pin_out,
  input  logic [5:0] pin_oe,
  // Level the host puts on pins the device leaves free
  input  logic [5:0] host_val,
  output logic [5:0] pin_in
);
  // Host only drives released pins, so no contention
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & host_val);
endmodule

// File: verif/pem_port_mux_sva.sv
// Port-level assertions for the pin function mux
`timescale 1ns/10ps
module pem_port_mux_sva
(
  // Clock, reset and write handshake
  input logic       aclk, aresetn,
  input logic       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input logic       s_axi_bvalid, s_axi_bready,
  // Pins, memory bus and strobes
  input logic [5:0] pin_out, pin_oe, bus_addr_data_out,
  input logic       bus_read_cycle, bus_active, slave_rd_n, slave_wr_n, slave_cs_n,
  // PWM sources
  input logic       pwm_module_one_enable, pwm_module_two_enable, pwm_module_three_enable,
  input logic       pwm_one_channel_c, pwm_two_channel_b, pwm_two_channel_c,
  input logic       pwm_two_channel_d, pwm_three_channel_b, pwm_three_channel_c
);
  logic [5:0] ch_q;
  logic [2:0] en_q;
  logic [5:0] pwm_bad;

  // Driven pins whose level differs from the delayed channel
  assign pwm_bad = (pin_out ^ ch_q) & pin_oe;

  // Channels in pin order, one cycle back to match the registered pins
  always @(posedge aclk)
  begin
    ch_q <= {pwm_one_channel_c, pwm_three_channel_b, pwm_three_channel_c,
             pwm_two_channel_b, pwm_two_channel_c, pwm_two_channel_d};
    en_q <= {pwm_module_one_enable, pwm_module_three_enable, pwm_module_two_enable};
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Two cycles of one owner keeps the check clear of the hand-over cycle
  sequence bus_owned;
    bus_active && $past(bus_active);
  endsequence
  sequence pwm_free;
    !bus_active && !$past(bus_active);
  endsequence

  wr_answer_a: assert property (w_take |=> s_axi_bvalid)
    else $error("write response missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  bus_drive_a: assert property (bus_owned |-> pin_out == $past(bus_addr_data_out))
    else $error("bus data not on pins");
  bus_dir_a: assert property (bus_owned |-> pin_oe == {6{!$past(bus_read_cycle)}})
    else $error("bus direction wrong");
  strobe_idle_a: assert property (bus_owned |-> slave_rd_n && slave_wr_n && slave_cs_n)
    else $error("strobes active under bus");
  pwm_two_a: assert property (pwm_free ##0 en_q[0] |-> (pwm_bad & 6'h07) == 6'h00)
    else $error("module two channels wrong");
  pwm_three_a: assert property (pwm_free ##0 en_q[1] |-> (pwm_bad & 6'h18) == 6'h00)
    else $error("module three channels wrong");
  pwm_one_a: assert property (pwm_free ##0 en_q[2] |-> (pwm_bad & 6'h20) == 6'h00)
    else $error("module one channel wrong");
endmodule

bind pem_port_mux pem_port_mux_sva u_sva (.*);

// File: verif/tb_pem_port_mux.sv
// Self-checking bench for the pin function mux
`timescale 1ns/10ps
`include "pem_defs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %0t: got %h want %h", $time, (g), (e)); end end
module tb_pem_port_mux;
  localparam logic [1:0] ok = `PEM_RESP_OKAY;
  logic        aclk = 0, aresetn = 0, bus_read_cycle = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  pin_in, pin_out, pin_oe, bus_addr_data_in;
  logic [5:0]  bus_addr_data_out = '0, host_val = '0, lat, dir, hv, ch;
  logic        bus_active, slave_rd_n, slave_wr_n, slave_cs_n;
  logic        pwm_module_one_enable = 0, pwm_module_two_enable = 0;
  logic        pwm_module_three_enable = 0, pwm_one_channel_c = 0;
  logic        pwm_two_channel_b = 0, pwm_two_channel_c = 0, pwm_two_channel_d = 0;
  logic        pwm_three_channel_b = 0, pwm_three_channel_c = 0;
  logic        pwm_one_shutdown = 0, pwm_two_shutdown = 0, pwm_three_shutdown = 0;
  logic [2:0]  sd, cf;
  int          n_errors = 0, checks_done = 0, k;

  pem_port_mux u_dut (.*);
  pem_pin_host u_host (.*);

  // Pins float only where shutdown meets its tristate option
  function automatic logic [5:0] pwm_oe(input logic [2:0] s, input logic [2:0] c);
    logic [2:0] z;
    z = s & c;
    return ~{z[0], {2{z[2]}}, {3{z[1]}}};
  endfunction

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic to_err();
    n_errors++;
    $display("unexpected %0t: wait ran out", $time);
    close_out();
  endtask

  // Output stage, three flops, filter and capture stage need six edges; eight for margin
  task automatic settle();
    repeat (8) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40 && s_axi_bvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (i == 40) to_err();
    `CHK(s_axi_bresp, r)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40 && s_axi_rvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (i == 40) to_err();
    `CHK(s_axi_rdata, d)
    `CHK(s_axi_rresp, r)
  endtask

  initial
  begin
    forever #2.5 aclk = ~aclk;
  end

  initial
  begin
    repeat (100000) @(posedge aclk);
    to_err();
  end

  initial
  begin
    void'($urandom(32'h8092_8e5f));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PEM_OFF_DIR, 32'h0000_003F, ok);
    rd(`PEM_OFF_MEMCTL, 32'h0000_0080, ok);
    rd(8'h18, 32'h0000_0000, `PEM_RESP_SLVERR);
    wr(8'h18, 8'h3C, `PEM_RESP_SLVERR);
    for (k = 0; k < 5; k++)
    begin
      lat = $urandom;
      hv = $urandom;
      dir = (k == 0) ? 6'h03 : $urandom;
      host_val <= hv;
      wr(k[0] ? `PEM_OFF_PORT : `PEM_OFF_LATCH, {2'b00, lat}, ok);
      wr(`PEM_OFF_DIR, {2'b00, dir}, ok);
      settle();
      `CHK(pin_oe, ~dir)
      `CHK(pin_out & ~dir, lat & ~dir)
      rd(`PEM_OFF_PORT, {26'h000_0000, hv & dir | lat & ~dir}, ok);
      rd(`PEM_OFF_LATCH, {26'h000_0000, lat}, ok);
    end
    // A write with lane zero masked is answered but must leave the latch alone
    s_axi_wstrb <= 4'h0;
    wr(`PEM_OFF_LATCH, 8'h3F, ok);
    s_axi_wstrb <= 4'hF;
    rd(`PEM_OFF_LATCH, {26'h000_0000, lat}, ok);
    wr(`PEM_OFF_DIR, 8'h00, ok);
    {pwm_module_one_enable, pwm_module_two_enable, pwm_module_three_enable} <= 3'b111;
    for (k = 0; k < 6; k++)
    begin
      ch = $urandom;
      sd = (k == 0) ? 3'b111 : $urandom;
      cf = (k == 0) ? 3'b111 : $urandom;
      wr(`PEM_OFF_PWMCFG, {5'b0_0000, cf}, ok);
      {pwm_one_channel_c, pwm_three_channel_b, pwm_three_channel_c,
        pwm_two_channel_b, pwm_two_channel_c, pwm_two_channel_d} <= ch;
      {pwm_three_shutdown, pwm_two_shutdown, pwm_one_shutdown} <= sd;
      settle();
      `CHK(pin_oe, pwm_oe(sd, cf))
      `CHK(pin_out & pwm_oe(sd, cf), ch & pwm_oe(sd, cf))
    end
    // Enabled modules must not drive pins whose direction bit is set
    wr(`PEM_OFF_DIR, 8'h3F, ok);
    settle();
    `CHK(pin_oe, 6'h00)
    `CHK(pin_out, lat)
    {pwm_module_one_enable, pwm_module_two_enable, pwm_module_three_enable} <= 3'b000;
    wr(`PEM_OFF_DIR, 8'h07, ok);
    wr(`PEM_OFF_SLVCTL, 8'h10, ok);
    for (k = 0; k < 3; k++)
    begin
      hv = $urandom;
      host_val <= hv;
      settle();
      `CHK({slave_cs_n, slave_wr_n, slave_rd_n}, hv[2:0])
      `CHK(pin_oe, 6'h38)
    end
    wr(`PEM_OFF_MEMCTL, 8'h00, ok);
    for (k = 0; k < 4; k++)
    begin
      hv = $urandom;
      ch = $urandom;
      host_val <= hv;
      bus_addr_data_out <= ch;
      bus_read_cycle <= k[0];
      settle();
      `CHK(bus_active, 1'b1)
      `CHK({slave_cs_n, slave_wr_n, slave_rd_n}, 3'b111)
      if (k[0])
        `CHK(bus_addr_data_in, hv)
      else
        `CHK(pin_out, ch)
      `CHK(pin_oe, {6{!k[0]}})
    end
    wr(`PEM_OFF_MEMCTL, 8'h80, ok);
    settle();
    `CHK(bus_active, 1'b0)
    `CHK(pin_oe, 6'h38)
    close_out();
  end
endmodule
